// >>> inc/ppo_pkg.sv
// Behaviour
// RQ1 - six-bit field per pin picks its output
// RQ2 - code zero leaves pin undriven
// RQ3 - codes 1 to 27 name peripheral outputs
// RQ4 - reset puts null code on every pin
// RQ5 - one field per pin and input: no contention
// RQ6 - one source may feed many sinks
// RQ7 - code of absent pin gives no input
// RQ8 - fields of absent pins ignore writes
// RQ9 - locked selector writes complete but change nothing
// RQ10 - map write lock is oscillator bit six
// RQ11 - software writes 46h, 57h, then lock
// RQ12 - lock holds until next valid sequence
// RQ13 - shadow copies compared, mismatch raises reset
// RQ14 - one-way mode forbids clearing the lock
// RQ15 - one-way and locked: sequence never arms
// RQ16 - one-way bit set when unprogrammed
// RQ17 - 24 or 15 pins, four and twelve absent
// RQ18 - input fields reset to ground code
// RQ19 - lock comes out of reset cleared
// RQ20 - two input fields per register, value names pin
// RQ21 - any other write abandons the sequence; the code keeps the first key on a repeated 46h and ignores non-word writes
package ppo_pkg;

	localparam int NUM_PINS     = 26;
	localparam int NUM_IN_FN    = 38;
	localparam int NUM_OUT_REGS = 13;
	localparam int NUM_IN_REGS  = 19;
	localparam int OUT_FN_LAST  = 27;
	localparam int ADDR_W       = 12;

	localparam logic [5:0]  SEL_NULL   = 6'h00;
	localparam logic [5:0]  SEL_GROUND = 6'h3f;
	localparam logic [5:0]  SEL_LAST   = 6'h1b;
	// pins 4 and 12 absent; pin 25 is input-only
	localparam logic [25:0] IO_MASK_LARGE = 26'h1ffefef;
	localparam logic [25:0] IN_MASK_LARGE = 26'h3ffefef;
	localparam logic [25:0] IO_MASK_SMALL = 26'h000efef;
	localparam logic [25:0] IN_MASK_SMALL = 26'h200efef;

	localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;
	localparam logic [11:0] STATUS_ADDR   = 12'h004;
	localparam logic [11:0] OUT_BASE      = 12'h100;
	localparam logic [11:0] IN_BASE       = 12'h200;

	localparam int          LOCK_BIT        = 6;
	localparam int          CFG_ONE_WAY_BIT = 15;
	localparam int          FIELD_HI        = 8;
	localparam logic [7:0]  KEY_FIRST       = 8'h46;
	localparam logic [7:0]  KEY_SECOND      = 8'h57;
	localparam logic [2:0]  HSIZE_WORD      = 3'h2;
	localparam logic [1:0]  CFG_CAP_CNT     = 2'h3;
	localparam int          STAT_ONE_WAY    = 0;
	localparam int          STAT_MISMATCH   = 1;
	localparam int          STAT_SEQ        = 2;

	localparam logic [2:0]  KIND_NONE = 3'h0;
	localparam logic [2:0]  KIND_OSC  = 3'h1;
	localparam logic [2:0]  KIND_STAT = 3'h2;
	localparam logic [2:0]  KIND_OUT  = 3'h3;
	localparam logic [2:0]  KIND_IN   = 3'h4;

	typedef logic [5:0] ppo_sel_t;

	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b001,
		SEQ_KEY1  = 3'b010,
		SEQ_ARMED = 3'b100
	} ppo_seq_t;

	typedef struct packed {
		ppo_sel_t [NUM_IN_FN-1:0] in_sel;
		ppo_sel_t [NUM_PINS-1:0]  out_sel;
	} ppo_map_t;

	localparam ppo_map_t MAP_RESET = '{
		in_sel:  {NUM_IN_FN{SEL_GROUND}},
		out_sel: {NUM_PINS{SEL_NULL}}
	};

	typedef struct packed {
		logic [2:0] kind;
		logic [4:0] idx;
	} ppo_dec_t;

	typedef struct packed {
		ppo_map_t              map;
		logic                  lock;
		ppo_seq_t              seq;
		logic                  one_way;
		logic                  cfg1;
		logic                  cfg2;
		logic [1:0]            cfg_cnt;
		logic [NUM_PINS-1:0]   sync1;
		logic [NUM_PINS-1:0]   sync2;
		logic                  wr_pend;
		logic                  rd_pend;
		logic [ADDR_W-1:0]     addr;
		logic                  hready;
		logic [31:0]           rdata;
		logic                  map_upd;
		logic [NUM_PINS-1:0]   pin_out;
		logic [NUM_PINS-1:0]   pin_oe;
		logic [NUM_IN_FN-1:0]  periph_in;
	} ppo_core_st_t;

	typedef struct packed {
		ppo_map_t shadow;
		logic     mismatch;
	} ppo_shadow_st_t;

endpackage

// >>> core/ppo_shadow_mon.sv
`timescale 1ns/1ps
module ppo_shadow_mon
	import ppo_pkg::*;
(
	// clock and reset
	input  wire logic     clk_i,
	input  wire logic     rst_i,
	// live map and legal update strobe
	input  wire ppo_map_t live_i,
	input  wire logic     upd_i,
	// mismatch reset request
	output logic          mismatch_o
);

	ppo_shadow_st_t st_q;
	ppo_shadow_st_t st_d;

	// shadow follows only legal writes; any other difference is an upset
	always_comb begin
		st_d = st_q;
		if (upd_i) begin
			st_d.shadow = live_i;
		end else if (live_i != st_q.shadow) begin
			st_d.mismatch = 1'b1; // [RQ13]
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '{shadow: MAP_RESET, mismatch: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign mismatch_o = st_q.mismatch;

	AST_MISMATCH_RAISE: assert property ( // [RQ13]
		@(posedge clk_i) disable iff (rst_i)
		(live_i != st_q.shadow && !upd_i) |=> mismatch_o)
		else $error("upset not flagged");
	AST_MISMATCH_STICKY: assert property ( // [RQ13]
		@(posedge clk_i) disable iff (rst_i)
		mismatch_o |=> mismatch_o)
		else $error("mismatch dropped");
	COV_MISMATCH: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(mismatch_o));

endmodule

// >>> core/ppo_pin_remap.sv
`timescale 1ns/1ps
module ppo_pin_remap
	import ppo_pkg::*;
#(
	parameter bit LARGE_PKG = 1'b1
)(
	// clock and reset
	input  wire logic                   SYS_CLK_I,
	input  wire logic                   SYS_RST_I,
	// ahb-lite slave
	input  wire logic                   HSEL_I,
	input  wire logic [ADDR_W-1:0]      HADDR_I,
	input  wire logic [1:0]             HTRANS_I,
	input  wire logic                   HWRITE_I,
	input  wire logic [2:0]             HSIZE_I,
	input  wire logic [31:0]            HWDATA_I,
	input  wire logic                   HREADY_I,
	output logic      [31:0]            HRDATA_O,
	output logic                        HREADYOUT_O,
	output logic                        HRESP_O,
	// remappable pins
	input  wire logic [NUM_PINS-1:0]    PIN_IN_I,
	output logic      [NUM_PINS-1:0]    PIN_OUT_O,
	output logic      [NUM_PINS-1:0]    PIN_OE_O,
	// peripherals
	input  wire logic [OUT_FN_LAST:1]   PERIPH_OUT_I,
	output logic      [NUM_IN_FN-1:0]   PERIPH_IN_O,
	// configuration
	input  wire logic [15:0]            CFG_WORD_FOUR_I,
	output logic                        CFG_MISMATCH_RST_O
);

	localparam logic [25:0] IO_MASK = LARGE_PKG ? IO_MASK_LARGE
		: IO_MASK_SMALL; // [RQ17]
	localparam logic [25:0] IN_MASK = LARGE_PKG ? IN_MASK_LARGE
		: IN_MASK_SMALL; // [RQ17]

	ppo_core_st_t st_q;
	ppo_core_st_t st_d;
	logic         hresp_q;

	// ****************************************
	// decoding
	// ****************************************

	function automatic ppo_dec_t decode(input logic [ADDR_W-1:0] a);
		ppo_dec_t r;
		r = '{kind: KIND_NONE, idx: 5'h00};
		if (a == OSC_CTRL_ADDR) begin
			r.kind = KIND_OSC;
		end else if (a == STATUS_ADDR) begin
			r.kind = KIND_STAT;
		end else if (a[1:0] == 2'b00 && a[11:8] == OUT_BASE[11:8]
				&& a[7:2] < 6'(NUM_OUT_REGS)) begin
			r.kind = KIND_OUT;
			r.idx  = a[6:2];
		end else if (a[1:0] == 2'b00 && a[11:8] == IN_BASE[11:8]
				&& a[7:2] < 6'(NUM_IN_REGS)) begin
			r.kind = KIND_IN;
			r.idx  = a[6:2];
		end
		return r;
	endfunction

	// codes above the table act as null
	function automatic logic out_valid(input ppo_sel_t c);
		return c != SEL_NULL && c <= SEL_LAST;
	endfunction

	// ****************************************
	// next state
	// ****************************************

	always_comb begin
		ppo_dec_t    dec;
		logic [31:0] rd;
		logic        fld_wr;
		dec    = decode(st_q.addr);
		rd     = 32'h0000_0000;
		fld_wr = 1'b0;
		st_d   = st_q;
		st_d.sync1   = PIN_IN_I;
		st_d.sync2   = st_q.sync1;
		st_d.cfg1    = CFG_WORD_FOUR_I[CFG_ONE_WAY_BIT];
		st_d.cfg2    = st_q.cfg1;
		st_d.map_upd = 1'b0;

		// strap caught once, after the synchroniser has filled
		if (st_q.cfg_cnt != CFG_CAP_CNT) begin
			st_d.cfg_cnt = st_q.cfg_cnt + 2'h1;
		end
		if (st_q.cfg_cnt == CFG_CAP_CNT - 2'h1) begin
			st_d.one_way = st_q.cfg2; // [RQ16]
		end

		// write data phase
		if (st_q.wr_pend && HREADY_I) begin
			if (dec.kind == KIND_OSC) begin
				case (st_q.seq)
					SEQ_IDLE: begin
						// one-way and locked: keys are ignored
						if (HWDATA_I[7:0] == KEY_FIRST
								&& !(st_q.one_way && st_q.lock)) begin
							st_d.seq = SEQ_KEY1; // [RQ15]
						end
					end
					SEQ_KEY1: begin
						if (HWDATA_I[7:0] == KEY_SECOND) begin
							st_d.seq = SEQ_ARMED;
						end else if (HWDATA_I[7:0] != KEY_FIRST) begin
							st_d.seq = SEQ_IDLE; // [RQ21]
						end
					end
					SEQ_ARMED: begin
						if (!(st_q.one_way && st_q.lock)) begin
							st_d.lock = HWDATA_I[LOCK_BIT]; // [RQ10] [RQ14] [RQ12]
						end
						st_d.seq = SEQ_IDLE;
					end
					default: begin
						st_d.seq = SEQ_IDLE;
					end
				endcase
			end else begin
				st_d.seq = SEQ_IDLE; // [RQ21]
			end

			// locked writes still complete on the bus
			if (!st_q.lock) begin // [RQ9]
				for (int p = 0; p < NUM_PINS; p++) begin
					if (dec.kind == KIND_OUT && dec.idx == 5'(p / 2)
							&& IO_MASK[p]) begin // [RQ8]
						st_d.map.out_sel[p] = (p % 2 == 1)
							? HWDATA_I[FIELD_HI+5:FIELD_HI]
							: HWDATA_I[5:0]; // [RQ1]
						fld_wr = 1'b1;
					end
				end
				for (int f = 0; f < NUM_IN_FN; f++) begin
					if (dec.kind == KIND_IN && dec.idx == 5'(f / 2)) begin
						st_d.map.in_sel[f] = (f % 2 == 1)
							? HWDATA_I[FIELD_HI+5:FIELD_HI]
							: HWDATA_I[5:0]; // [RQ20]
						fld_wr = 1'b1;
					end
				end
			end
			st_d.map_upd = fld_wr; // [RQ13]
		end

		// read data phase: one wait state so prior writes are seen
		if (st_q.rd_pend && !st_q.hready) begin
			case (dec.kind)
				KIND_OSC: begin
					rd[LOCK_BIT] = st_q.lock;
				end
				KIND_STAT: begin
					rd[STAT_ONE_WAY]  = st_q.one_way;
					rd[STAT_MISMATCH] = CFG_MISMATCH_RST_O;
					rd[STAT_SEQ+2:STAT_SEQ] = st_q.seq;
				end
				KIND_OUT: begin
					for (int p = 0; p < NUM_PINS; p++) begin
						if (dec.idx == 5'(p / 2)) begin
							if (p % 2 == 1) begin
								rd[FIELD_HI+5:FIELD_HI] = st_q.map.out_sel[p];
							end else begin
								rd[5:0] = st_q.map.out_sel[p];
							end
						end
					end
				end
				KIND_IN: begin
					for (int f = 0; f < NUM_IN_FN; f++) begin
						if (dec.idx == 5'(f / 2)) begin
							if (f % 2 == 1) begin
								rd[FIELD_HI+5:FIELD_HI] = st_q.map.in_sel[f];
							end else begin
								rd[5:0] = st_q.map.in_sel[f];
							end
						end
					end
				end
				default: begin
					rd = 32'h0000_0000;
				end
			endcase
			st_d.rdata  = rd;
			st_d.hready = 1'b1;
		end

		// address phase
		if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
			st_d.wr_pend = HWRITE_I && HSIZE_I == HSIZE_WORD;
			st_d.rd_pend = !HWRITE_I;
			st_d.addr    = HADDR_I;
			st_d.hready  = HWRITE_I;
		end else if (HREADY_I) begin
			st_d.wr_pend = 1'b0;
			st_d.rd_pend = 1'b0;
		end

		// one field per pin and per input: no two drivers can meet
		for (int p = 0; p < NUM_PINS; p++) begin
			st_d.pin_oe[p]  = out_valid(st_q.map.out_sel[p]); // [RQ2] [RQ3] [RQ5]
			st_d.pin_out[p] = st_d.pin_oe[p]
				? PERIPH_OUT_I[st_q.map.out_sel[p]] : 1'b0; // [RQ1] [RQ6]
		end
		for (int f = 0; f < NUM_IN_FN; f++) begin
			st_d.periph_in[f] = (st_q.map.in_sel[f] < 6'(NUM_PINS)
				&& IN_MASK[st_q.map.in_sel[f][4:0]])
				? st_q.sync2[st_q.map.in_sel[f][4:0]] : 1'b0; // [RQ7] [RQ6]
		end
	end

	// ****************************************
	// registers
	// ****************************************

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			st_q <= '{
				map:       MAP_RESET, // [RQ4] [RQ18]
				lock:      1'b0, // [RQ19]
				seq:       SEQ_IDLE,
				one_way:   1'b1, // [RQ16]
				cfg1:      1'b1,
				cfg2:      1'b1,
				cfg_cnt:   2'h0,
				sync1:     '0,
				sync2:     '0,
				wr_pend:   1'b0,
				rd_pend:   1'b0,
				addr:      '0,
				hready:    1'b1,
				rdata:     32'h0000_0000,
				map_upd:   1'b0,
				pin_out:   '0,
				pin_oe:    '0,
				periph_in: '0
			};
			hresp_q <= 1'b0;
		end else begin
			st_q    <= st_d;
			hresp_q <= 1'b0;
		end
	end

	ppo_shadow_mon u_shadow (
		.clk_i      (SYS_CLK_I),
		.rst_i      (SYS_RST_I),
		.live_i     (st_q.map),
		.upd_i      (st_q.map_upd),
		.mismatch_o (CFG_MISMATCH_RST_O)
	);

	assign HRDATA_O    = st_q.rdata;
	assign HREADYOUT_O = st_q.hready;
	assign HRESP_O     = hresp_q;
	assign PIN_OUT_O   = st_q.pin_out;
	assign PIN_OE_O    = st_q.pin_oe;
	assign PERIPH_IN_O = st_q.periph_in;

	// ****************************************
	// checks
	// ****************************************

	logic seen_wr_q;
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			seen_wr_q <= 1'b0;
		end else if (st_q.map_upd) begin
			seen_wr_q <= 1'b1;
		end
	end

	// seen_wr_q trails the update strobe by one edge, so the strobe is excluded
	AST_RESET_NULL: assert property ( // [RQ4]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		!seen_wr_q && !st_q.map_upd
		|-> PIN_OE_O == '0 && st_q.map == MAP_RESET)
		else $error("map left reset state without a write");
	AST_NULL_UNDRIVEN: assert property ( // [RQ2]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.map.out_sel[0] == SEL_NULL |=> !PIN_OE_O[0])
		else $error("null code drove a pin");
	AST_DRIVE_SOURCE: assert property ( // [RQ1]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		out_valid(st_q.map.out_sel[1]) |=> PIN_OE_O[1] &&
		PIN_OUT_O[1] == $past(PERIPH_OUT_I[st_q.map.out_sel[1]]))
		else $error("pin not following its source");
	AST_BAD_CODE: assert property ( // [RQ3]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.map.out_sel[2] > SEL_LAST |=> !PIN_OE_O[2])
		else $error("unlisted code drove a pin");
	AST_ABSENT_FIELD: assert property ( // [RQ8]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.map.out_sel[4] == SEL_NULL
		&& st_q.map.out_sel[12] == SEL_NULL)
		else $error("absent pin field changed");
	AST_INVALID_IN: assert property ( // [RQ7]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		(st_q.map.in_sel[0] >= 6'(NUM_PINS) || st_q.map.in_sel[0] == 6'h04)
		|=> !PERIPH_IN_O[0])
		else $error("invalid input code reached peripheral");
	// pin 1 exists as an input in both variants
	AST_IN_ROUTE: assert property ( // [RQ20]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.map.in_sel[0] == 6'h01
		|=> PERIPH_IN_O[0] == $past(st_q.sync2[1]))
		else $error("input not routed from its pin");
	AST_WRITE_LANDS: assert property ( // [RQ1]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.wr_pend && HREADY_I && !st_q.lock && st_q.addr == OUT_BASE
		|=> st_q.map.out_sel[0] == $past(HWDATA_I[5:0]))
		else $error("selector write did not land");
	AST_LOCKED_HOLD: assert property ( // [RQ9]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.lock |=> $stable(st_q.map))
		else $error("selector changed while locked");
	AST_LOCK_CAUSE: assert property ( // [RQ12]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		$changed(st_q.lock) |-> $past(st_q.seq) == SEQ_ARMED)
		else $error("lock changed without sequence");
	AST_ONE_WAY: assert property ( // [RQ14] [RQ15]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.one_way && st_q.lock |=> st_q.lock && st_q.seq == SEQ_IDLE)
		else $error("one-way lock released or armed");
	AST_ABANDON: assert property ( // [RQ21]
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.wr_pend && HREADY_I && st_q.addr != OSC_CTRL_ADDR
		|=> st_q.seq == SEQ_IDLE)
		else $error("sequence survived a foreign write");
	COV_LOCK_SET: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		$rose(st_q.lock));
	COV_ARMED: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		st_q.seq == SEQ_ARMED);
	COV_PIN_DRIVEN: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		$rose(PIN_OE_O[0]));
	COV_READ: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		!HREADYOUT_O ##1 HREADYOUT_O);

endmodule

// >>> bench/ppo_periph_model.sv
`timescale 1ns/1ps
module ppo_periph_model
	import ppo_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// step to the next pattern
	input  wire logic                 adv_i,
	// peripheral outputs and pin levels
	output logic      [OUT_FN_LAST:1] periph_out_o,
	output logic      [NUM_PINS-1:0]  pin_in_o
);
	// ****************************************
	// pattern source
	// ****************************************
	// levels only move on request, so the bench can settle them
	logic [31:0] st_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= 32'h9e3779b9;
		end else if (adv_i) begin
			st_q <= st_q * 32'h0019660d + 32'h3c6ef35f;
		end
	end

	assign periph_out_o = st_q[26:0];
	assign pin_in_o     = st_q[31:6] ^ st_q[25:0];
endmodule

// >>> bench/ppo_pin_remap_tb.sv
`timescale 1ns/1ps
module ppo_pin_remap_tb
	import ppo_pkg::*;
();
	// ****************************************
	// signals
	// ****************************************
	logic                 clk;
	logic                 rst;
	logic                 hsel;
	logic                 hwrite;
	logic                 adv;
	logic                 hready;
	logic                 hresp;
	logic                 mism;
	logic [1:0]           htrans;
	logic [2:0]           hsize;
	logic [11:0]          haddr;
	logic [31:0]          hwdata;
	logic [31:0]          hrdata;
	logic [31:0]          lfsr_q;
	logic [15:0]          cfg;
	logic [NUM_PINS-1:0]  pin_in;
	logic [NUM_PINS-1:0]  pin_out;
	logic [NUM_PINS-1:0]  pin_oe;
	logic [27:1]          pout;
	logic [NUM_IN_FN-1:0] pin_fn;
	logic [5:0]           ocode [NUM_PINS];
	logic [5:0]           icode [NUM_IN_FN];
	int                   err_count;
	int                   n_compared;
	int                   cyc;

	ppo_pin_remap #(.LARGE_PKG(1'b1)) i_dut (
		.SYS_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe),
		.PERIPH_OUT_I(pout), .PERIPH_IN_O(pin_fn),
		.CFG_WORD_FOUR_I(cfg), .CFG_MISMATCH_RST_O(mism)
	);

	ppo_periph_model i_model (
		.clk_i(clk), .rst_i(rst), .adv_i(adv),
		.periph_out_o(pout), .pin_in_o(pin_in)
	);

	// ****************************************
	// helpers
	// ****************************************
	task automatic summarize();
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction

	task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t read %h want %h", $time, g, e);
		end
	endtask

	task automatic chk_vec(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t pins %h want %h", $time, g, e);
		end
	endtask

	// address phase held until hready, then data phase until hready
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
		chk_rd(32'(hresp), 32'h0);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk_rd(x, e);
	endtask

	task automatic key(input logic v);
		wr(OSC_CTRL_ADDR, 32'h46);
		wr(OSC_CTRL_ADDR, 32'h57);
		wr(OSC_CTRL_ADDR, {25'h0, v, 6'h0});
	endtask

	task automatic init_exp();
		foreach (ocode[p]) ocode[p] = SEL_NULL;
		foreach (icode[f]) icode[f] = SEL_GROUND;
	endtask

	function automatic logic [63:0] exp_fn();
		logic [63:0] r;
		r = '0;
		foreach (icode[f]) begin
			if (icode[f] < 6'd26 && IN_MASK_LARGE[icode[f]]) begin
				r[f] = pin_in[icode[f]];
			end
		end
		return r;
	endfunction

	task automatic chk_map();
		logic [63:0] oe;
		logic [63:0] out;
		adv <= 1'b1;
		@(posedge clk);
		adv <= 1'b0;
		repeat (4) @(posedge clk);
		oe  = '0;
		out = '0;
		foreach (ocode[p]) begin
			oe[p] = ocode[p] >= 6'h01 && ocode[p] <= SEL_LAST;
			if (oe[p]) begin
				out[p] = pout[ocode[p]];
			end
		end
		chk_vec(64'(pin_oe), oe);
		chk_vec(64'(pin_out), out);
		chk_vec(64'(pin_fn), exp_fn());
	endtask

	task automatic code_of(input int k, input int i, output logic [5:0] c);
		logic [31:0] r;
		r = rnd();
		case (k)
			0: c = 6'(i + 1);
			1: c = 6'(27 - i);
			2: c = 6'h03;
			default: c = r[5:0];
		endcase
	endtask

	task automatic set_map(input int k);
		logic [5:0] c0;
		logic [5:0] c1;
		for (int r = 0; r < NUM_OUT_REGS; r++) begin
			code_of(k, 2 * r, c0);
			code_of(k, 2 * r + 1, c1);
			wr(OUT_BASE + 12'(4 * r), {18'h0, c1, 2'h0, c0});
			ocode[2 * r]     = IO_MASK_LARGE[2 * r] ? c0 : SEL_NULL;
			ocode[2 * r + 1] = IO_MASK_LARGE[2 * r + 1] ? c1 : SEL_NULL;
			rd_chk(OUT_BASE + 12'(4 * r),
				{18'h0, ocode[2 * r + 1], 2'h0, ocode[2 * r]});
		end
		for (int r = 0; r < NUM_IN_REGS; r++) begin
			code_of(k, 2 * r, c0);
			code_of(k, 2 * r + 1, c1);
			icode[2 * r]     = c0;
			icode[2 * r + 1] = c1;
			wr(IN_BASE + 12'(4 * r), {18'h0, c1, 2'h0, c0});
			rd_chk(IN_BASE + 12'(4 * r), {18'h0, c1, 2'h0, c0});
		end
		chk_map();
	endtask

	// ****************************************
	// clock, timeout and main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		{hsel, hwrite, adv, htrans, haddr, hwdata} = '0;
		hsize      = HSIZE_WORD;
		rst        = 1'b1;
		cfg        = 16'h8000;
		lfsr_q     = 32'hc2ce5d27;
		err_count  = 0;
		n_compared = 0;
		cyc        = 0;
		init_exp();
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(OUT_BASE, 32'h0);
		rd_chk(IN_BASE, 32'h3f3f);
		rd_chk(OSC_CTRL_ADDR, 32'h0);
		rd_chk(STATUS_ADDR, 32'h5);
		chk_map();
		for (int k = 0; k < 5; k++) set_map(k);
		rd_chk(12'hffc, 32'h0);
		// non-word writes are dropped by the slave
		hsize <= 3'h0;
		wr(OUT_BASE, 32'h0505);
		hsize <= HSIZE_WORD;
		rd_chk(OUT_BASE, {18'h0, ocode[1], 2'h0, ocode[0]});
		key(1'b1);
		rd_chk(OSC_CTRL_ADDR, 32'h40);
		wr(OUT_BASE, 32'h0505);
		wr(IN_BASE, 32'h0);
		rd_chk(OUT_BASE, {18'h0, ocode[1], 2'h0, ocode[0]});
		rd_chk(IN_BASE, {18'h0, icode[1], 2'h0, icode[0]});
		chk_map();
		key(1'b0);
		rd_chk(OSC_CTRL_ADDR, 32'h40);
		wr(OSC_CTRL_ADDR, 32'h46);
		rd_chk(STATUS_ADDR, 32'h5);
		wr(OUT_BASE, 32'h0505);
		rd_chk(OUT_BASE, {18'h0, ocode[1], 2'h0, ocode[0]});
		chk_vec(64'(mism), 64'h0);
		// second reset with unlimited sessions
		rst <= 1'b1;
		cfg <= 16'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		init_exp();
		rd_chk(STATUS_ADDR, 32'h4);
		wr(OSC_CTRL_ADDR, 32'h46);
		wr(OUT_BASE + 12'h4, 32'h0101);
		ocode[2] = 6'h01;
		ocode[3] = 6'h01;
		wr(OSC_CTRL_ADDR, 32'h57);
		wr(OSC_CTRL_ADDR, 32'h40);
		rd_chk(OSC_CTRL_ADDR, 32'h0);
		key(1'b1);
		rd_chk(OSC_CTRL_ADDR, 32'h40);
		key(1'b0);
		rd_chk(OSC_CTRL_ADDR, 32'h0);
		set_map(5);
		key(1'b1);
		key(1'b0);
		rd_chk(OSC_CTRL_ADDR, 32'h0);
		chk_vec(64'(mism), 64'h0);
		summarize();
	end
endmodule
